// ==== hw/gpp_regs.vh ====
`ifndef GPP_REGS_VH
`define GPP_REGS_VH

// ****************************************************************
// Port count and pin width
// ****************************************************************
`define GPP_NUM_PORTS   8
`define GPP_PORT_WIDTH  8

// ****************************************************************
// Configuration register select codes
// ****************************************************************
`define GPP_SEL_DIR     3'h0
`define GPP_SEL_AFSEL   3'h1
`define GPP_SEL_DEN     3'h2
`define GPP_SEL_PDR     3'h3
`define GPP_SEL_PUR     3'h4
`define GPP_SEL_DATA    3'h5

// ****************************************************************
// Reset values and debug pin locations
// ****************************************************************
`define GPP_RST_ZERO    8'h00
`define GPP_DBG_MASK_B  8'h80
`define GPP_DBG_MASK_C  8'h0F
`define GPP_PORT_B      3'h1
`define GPP_PORT_C      3'h2
`define GPP_TRST_BIT    7

`endif

// ==== hw/gpp_top.v ====
// Summary of operation
// - Ordinary pins reset undriven, all controls cleared
// - Debug pins reset to alternate, enabled, pulled up
// - Any reset restores both pin groups' defaults
// - Port B bit 7 returns to test-reset after reset
// - Eight instances of one port module, own register sets and reset masks
// - Direction picks input capture or output drive
// - Direction 0 captures pad, 1 drives data bit
// - Address bits 9:2 mask data writes and reads
`timescale 1ns/10ps
`include "gpp_regs.vh"

// ****************************************************************
// One port: configuration, pin data and pad control
// ****************************************************************
module gpp_port #(
	parameter       W        = `GPP_PORT_WIDTH,
	parameter [7:0] DBG_MASK = `GPP_RST_ZERO
) (
	input  wire         clk_sys_in,
	input  wire         resetn_in,
	input  wire         cfg_wr_in,
	input  wire [2:0]   cfg_sel_in,
	input  wire [W-1:0] cfg_wdata_in,
	input  wire         data_wr_in,
	input  wire [W-1:0] data_mask_in,
	input  wire [W-1:0] data_wdata_in,
	input  wire [W-1:0] pad_in,
	input  wire [W-1:0] alt_out_in,
	input  wire [W-1:0] alt_oe_in,
	output reg  [W-1:0] pad_out,
	output reg  [W-1:0] pad_oe_out,
	output reg  [W-1:0] alt_in_out,
	output wire [W-1:0] direction_reg_out,
	output wire [W-1:0] alt_function_select_out,
	output wire [W-1:0] digital_enable_reg_out,
	output wire [W-1:0] pull_down_select_out,
	output wire [W-1:0] pull_up_select_out,
	output wire [W-1:0] pin_data_reg_out
);
	reg  [W-1:0] direction_reg;        // Per-pin direction, 1 drives the pad
	reg  [W-1:0] alt_function_select;  // Per-pin peripheral ownership
	reg  [W-1:0] digital_enable_reg;   // Per-pin digital path enable
	reg  [W-1:0] pull_down_select;     // Per-pin pull-down control
	reg  [W-1:0] pull_up_select;       // Per-pin pull-up control
	reg  [W-1:0] pin_data_reg;         // Per-pin data, captured or driven
	reg  [W-1:0] pad_meta;     // First synchroniser stage
	reg  [W-1:0] pad_sync;     // Second synchroniser stage
	wire [W-1:0] pad_capture;  // Pad level seen through digital enable
	wire [W-1:0] next_data;    // Next pin data value

	assign pad_capture = pad_sync & digital_enable_reg;

	// Register contents seen by the top for readback and pad controls
	assign direction_reg_out       = direction_reg;
	assign alt_function_select_out = alt_function_select;
	assign digital_enable_reg_out  = digital_enable_reg;
	assign pull_down_select_out    = pull_down_select;
	assign pull_up_select_out      = pull_up_select;
	assign pin_data_reg_out        = pin_data_reg;

	// ****************************************************************
	// Pin data: inputs capture, outputs keep masked writes
	// ****************************************************************
	genvar b;
	generate
		for (b = 0; b < W; b = b + 1) begin : g_bit
			assign next_data[b] = !direction_reg[b] ? pad_capture[b] :
				((data_wr_in && data_mask_in[b]) ? data_wdata_in[b] :
				pin_data_reg[b]);
		end
	endgenerate

	// ****************************************************************
	// Registers and pad drive
	// ****************************************************************
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			// Debug pins come up in their debug role, others tristate
			direction_reg       <= `GPP_RST_ZERO;
			alt_function_select <= DBG_MASK;
			digital_enable_reg  <= DBG_MASK;
			pull_down_select    <= `GPP_RST_ZERO;
			pull_up_select      <= DBG_MASK;
			pin_data_reg        <= `GPP_RST_ZERO;
			pad_meta            <= DBG_MASK;
			pad_sync            <= DBG_MASK;
			pad_out             <= `GPP_RST_ZERO;
			pad_oe_out          <= `GPP_RST_ZERO;
			alt_in_out          <= DBG_MASK;
		end else begin
			// Two-stage synchroniser on pad inputs
			pad_meta <= pad_in;
			pad_sync <= pad_meta;
			// Configuration writes
			if (cfg_wr_in) begin
				case (cfg_sel_in)
					`GPP_SEL_DIR: begin
						direction_reg <= cfg_wdata_in;
					end
					`GPP_SEL_AFSEL: begin
						alt_function_select <= cfg_wdata_in;
					end
					`GPP_SEL_DEN: begin
						digital_enable_reg <= cfg_wdata_in;
					end
					`GPP_SEL_PDR: begin
						pull_down_select <= cfg_wdata_in;
					end
					`GPP_SEL_PUR: begin
						pull_up_select <= cfg_wdata_in;
					end
					default: begin
					end
				endcase
			end
			pin_data_reg <= next_data;
			// Alternate function owns the pad where selected
			pad_out    <= (alt_function_select & alt_out_in) |
				(~alt_function_select & pin_data_reg);
			pad_oe_out <= digital_enable_reg & ((alt_function_select & alt_oe_in) |
				(~alt_function_select & direction_reg));
			alt_in_out <= pad_capture & alt_function_select;
		end
	end
endmodule

// ****************************************************************
// Top: eight ports, shared access ports, readback
// ****************************************************************
module gpp_top #(
	parameter N = `GPP_NUM_PORTS,
	parameter W = `GPP_PORT_WIDTH
) (
	input  wire           clk_sys_in,
	input  wire           resetn_in,
	input  wire           cfg_wr_in,
	input  wire           cfg_rd_in,
	input  wire [2:0]     cfg_port_in,
	input  wire [2:0]     cfg_sel_in,
	input  wire [W-1:0]   cfg_wdata_in,
	input  wire           data_wr_in,
	input  wire [9:2]     data_addr_in,
	input  wire [W-1:0]   data_wdata_in,
	input  wire [N*W-1:0] pad_in,
	input  wire [N*W-1:0] alt_out_in,
	input  wire [N*W-1:0] alt_oe_in,
	output wire [N*W-1:0] pad_out,
	output wire [N*W-1:0] pad_oe_out,
	output wire [N*W-1:0] pull_up_out,
	output wire [N*W-1:0] pull_down_out,
	output wire [N*W-1:0] alt_in_out,
	output reg  [W-1:0]   cfg_rdata_out,
	output reg            test_reset_n_out
);
	wire [N*W-1:0] dir_all;    // Direction registers of all ports
	wire [N*W-1:0] afsel_all;  // Alternate select registers
	wire [N*W-1:0] den_all;    // Digital enable registers
	wire [N*W-1:0] data_all;   // Pin data registers
	reg  [W-1:0]   next_rdata; // Selected readback word

	// Decodes whether an access targets a given port
	function port_hit;
		input [2:0] sel;
		input [2:0] idx;
		begin
			port_hit = (sel == idx);
		end
	endfunction

	// ****************************************************************
	// Port instances
	// ****************************************************************
	genvar p;
	generate
		for (p = 0; p < N; p = p + 1) begin : g_port
			gpp_port #(
				.W        (W),
				.DBG_MASK ((p == `GPP_PORT_B) ? `GPP_DBG_MASK_B :
					((p == `GPP_PORT_C) ? `GPP_DBG_MASK_C : `GPP_RST_ZERO))
			) u_port (
				.clk_sys_in              (clk_sys_in),
				.resetn_in               (resetn_in),
				.cfg_wr_in               (cfg_wr_in && port_hit(cfg_port_in, p[2:0])),
				.cfg_sel_in              (cfg_sel_in),
				.cfg_wdata_in            (cfg_wdata_in),
				.data_wr_in              (data_wr_in && port_hit(cfg_port_in, p[2:0])),
				.data_mask_in            (data_addr_in),
				.data_wdata_in           (data_wdata_in),
				.pad_in                  (pad_in[p*W +: W]),
				.alt_out_in              (alt_out_in[p*W +: W]),
				.alt_oe_in               (alt_oe_in[p*W +: W]),
				.pad_out                 (pad_out[p*W +: W]),
				.pad_oe_out              (pad_oe_out[p*W +: W]),
				.alt_in_out              (alt_in_out[p*W +: W]),
				.direction_reg_out       (dir_all[p*W +: W]),
				.alt_function_select_out (afsel_all[p*W +: W]),
				.digital_enable_reg_out  (den_all[p*W +: W]),
				.pull_down_select_out    (pull_down_out[p*W +: W]),
				.pull_up_select_out      (pull_up_out[p*W +: W]),
				.pin_data_reg_out        (data_all[p*W +: W])
			);
		end
	endgenerate

	// ****************************************************************
	// Readback select; pin data reads are masked by address
	// ****************************************************************
	always @* begin
		case (cfg_sel_in)
			`GPP_SEL_DIR:   next_rdata = dir_all[cfg_port_in*W +: W];
			`GPP_SEL_AFSEL: next_rdata = afsel_all[cfg_port_in*W +: W];
			`GPP_SEL_DEN:   next_rdata = den_all[cfg_port_in*W +: W];
			`GPP_SEL_PDR:   next_rdata = pull_down_out[cfg_port_in*W +: W];
			`GPP_SEL_PUR:   next_rdata = pull_up_out[cfg_port_in*W +: W];
			`GPP_SEL_DATA:  next_rdata = data_all[cfg_port_in*W +: W] & data_addr_in;
			default:        next_rdata = `GPP_RST_ZERO;
		endcase
	end

	// ****************************************************************
	// Readback and debug test-reset output
	// ****************************************************************
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cfg_rdata_out    <= `GPP_RST_ZERO;
			test_reset_n_out <= 1'b1;
		end else begin
			// Read data holds until the next read
			if (cfg_rd_in) begin
				cfg_rdata_out <= next_rdata;
			end
			// Low pin resets the test controller while in debug role
			test_reset_n_out <= ~afsel_all[`GPP_PORT_B*W + `GPP_TRST_BIT] |
				alt_in_out[`GPP_PORT_B*W + `GPP_TRST_BIT];
		end
	end
endmodule

// ==== testbench/gpp_checker.sv ====
`timescale 1ns/10ps
`include "gpp_regs.vh"
module gpp_checker #(
	parameter N = 8,
	parameter W = 8
) (
	input wire           clk_sys_in,
	input wire           resetn_in,
	input wire           cfg_wr_in,
	input wire           cfg_rd_in,
	input wire [2:0]     cfg_port_in,
	input wire [2:0]     cfg_sel_in,
	input wire [W-1:0]   cfg_wdata_in,
	input wire [9:2]     data_addr_in,
	input wire [N*W-1:0] pad_in,
	input wire [N*W-1:0] pad_oe_out,
	input wire [N*W-1:0] pull_up_out,
	input wire [N*W-1:0] pull_down_out,
	input wire [W-1:0]   cfg_rdata_out,
	input wire           test_reset_n_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	reg b7_alt; // Shadow of the port B bit 7 select
	// ****************************************************************
	// Track the test-reset pin mode
	// ****************************************************************
	always @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in)
			b7_alt <= 1'b1;
		else if (cfg_wr_in && cfg_port_in == `GPP_PORT_B && cfg_sel_in == `GPP_SEL_AFSEL)
			b7_alt <= cfg_wdata_in[`GPP_TRST_BIT];
	end
	sequence s_b7_low; (b7_alt && !pad_in[15]) [*6]; endsequence
	sequence s_b7_gpio; !b7_alt [*2]; endsequence
	property p_rst_off; $rose(resetn_in) |-> pad_oe_out == 0 && pull_down_out == 0; endproperty
	property p_rst_dbg; $rose(resetn_in) |-> pull_up_out == 64'h0000_0000_000F_8000; endproperty
	property p_rst_trst; $rose(resetn_in) |-> test_reset_n_out; endproperty
	property p_trst_low; s_b7_low |-> !test_reset_n_out; endproperty
	property p_trst_gpio; s_b7_gpio |-> test_reset_n_out; endproperty
	property p_pur_wr; cfg_wr_in && cfg_sel_in == `GPP_SEL_PUR |=> ##1
		pull_up_out[$past(cfg_port_in, 2)*8 +: 8] == $past(cfg_wdata_in, 2); endproperty
	property p_pdr_wr; cfg_wr_in && cfg_sel_in == `GPP_SEL_PDR |=> ##1
		pull_down_out[$past(cfg_port_in, 2)*8 +: 8] == $past(cfg_wdata_in, 2); endproperty
	property p_rd_mask; cfg_rd_in && cfg_sel_in == `GPP_SEL_DATA |=>
		(cfg_rdata_out & ~$past(data_addr_in)) == 0; endproperty
	a_rst_off: assert property (p_rst_off) else $error("pin driven after reset");
	a_rst_dbg: assert property (p_rst_dbg) else $error("debug pull-ups wrong");
	a_rst_trst: assert property (p_rst_trst) else $error("test reset low");
	a_trst_low: assert property (p_trst_low) else $error("test reset missed");
	a_trst_gpio: assert property (p_trst_gpio) else $error("test reset in gpio");
	a_pur_wr: assert property (p_pur_wr) else $error("pull-up not written");
	a_pdr_wr: assert property (p_pdr_wr) else $error("pull-down not written");
	a_rd_mask: assert property (p_rd_mask) else $error("masked bit read");
endmodule

// ==== testbench/gpp_board.sv ====
`timescale 1ns/10ps
module gpp_board (
	input  wire        clk_sys_in,
	input  wire        resetn_in,
	input  wire [63:0] pad_out_in,
	input  wire [63:0] pad_oe_in,
	input  wire [63:0] pull_up_in,
	input  wire [63:0] pull_down_in,
	input  wire [63:0] ext_en_in,
	input  wire [63:0] ext_val_in,
	output wire [63:0] pad_level_out
);
	reg  [63:0] flt = 64'hA5A5_5A5A_0F0F_F0F0; // Floating pins wander
	wire [63:0] drv = resetn_in ? ext_en_in : ext_en_in & ~64'h0000_0000_0000_8000;
	always @(posedge clk_sys_in) flt <= ~flt;
	// Device drive wins, then the probe, then pulls
	assign pad_level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & drv & ext_val_in)
		| (~pad_oe_in & ~drv & (pull_up_in | (~pull_down_in & flt)));
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
`include "gpp_regs.vh"
module tb_top;
	reg         clk = 1'b0;
	reg         rst_n = 1'b0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg         dwr = 1'b0;
	reg  [2:0]  port = 3'h0;
	reg  [2:0]  sel = 3'h0;
	reg  [7:0]  wdata = 8'h00;
	reg  [7:0]  mask = 8'h00;
	reg  [7:0]  v;
	reg  [63:0] ext_en = 64'h0;
	reg  [63:0] ext_val = 64'h0;
	reg  [63:0] alt_o = 64'h0000_0000_0008_0000;
	wire [63:0] pad, oe, po, pu, pd, ai;
	wire [7:0]  rdata;
	wire        trst;
	integer     failures = 0;
	integer     n_tests = 0;
	integer     cycles = 0;
	gpp_top u_gpp_top (.clk_sys_in(clk), .resetn_in(rst_n), .cfg_wr_in(wr), .cfg_rd_in(rd),
		.cfg_port_in(port), .cfg_sel_in(sel), .cfg_wdata_in(wdata), .data_wr_in(dwr),
		.data_addr_in(mask), .data_wdata_in(wdata), .pad_in(pad), .alt_out_in(alt_o),
		.alt_oe_in(alt_o), .pad_out(po), .pad_oe_out(oe), .pull_up_out(pu),
		.pull_down_out(pd), .alt_in_out(ai), .cfg_rdata_out(rdata), .test_reset_n_out(trst));
	gpp_board u_gpp_board (.clk_sys_in(clk), .resetn_in(rst_n), .pad_out_in(po), .pad_oe_in(oe),
		.pull_up_in(pu), .pull_down_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val),
		.pad_level_out(pad));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles > 3000) begin
			failures = failures + 1;
			test_done;
		end
	end
	task tick;
		@(posedge clk);
		#1;
	endtask
	task chk(input [63:0] got, input [63:0] exp, input [8*5-1:0] what);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("MISMATCH %0s exp %h got %h", what, exp, got);
		end
	endtask
	// One access: k 0 config write, 1 readback, 2 pin-data write
	task acc(input [1:0] k, input [2:0] p, input [2:0] s, input [7:0] m, input [7:0] d);
		port = p;
		sel = s;
		mask = m;
		wdata = d;
		{dwr, rd, wr} = 3'b001 << k;
		tick;
		{dwr, rd, wr} = 3'b000;
		tick;
		v = rdata;
	endtask
	task t_defaults;
		repeat (4) tick;
		chk(pu, 64'h0000_0000_000F_8000, "pu");
		chk(pd, 64'h0, "pd");
		chk(oe, 64'h0000_0000_0008_0000, "oe");
		chk(ai, 64'h0000_0000_000F_8000, "ai");
		chk(trst, 1'b1, "trst");
		acc(2'd1, `GPP_PORT_B, `GPP_SEL_AFSEL, 8'h00, 8'h00);
		chk(v, 8'h80, "afs");
	endtask
	task t_out;
		acc(2'd0, 3'h0, `GPP_SEL_DEN, 8'h00, 8'hFF);
		acc(2'd0, 3'h0, `GPP_SEL_DIR, 8'h00, 8'hFF);
		acc(2'd2, 3'h0, 3'h0, 8'hFF, 8'h00);
		acc(2'd2, 3'h0, 3'h0, 8'hF0, 8'hA5);
		chk(oe[7:0], 8'hFF, "oe");
		chk(po[7:0], 8'hA0, "po");
		acc(2'd1, 3'h0, `GPP_SEL_DATA, 8'h3C, 8'h00);
		chk(v, 8'h20, "rd");
	endtask
	task t_in;
		ext_en = 64'h0000_0000_FF00_0000;
		ext_val = 64'h0000_0000_5A00_0000;
		acc(2'd0, 3'h3, `GPP_SEL_DEN, 8'h00, 8'hFF);
		acc(2'd2, 3'h3, 3'h0, 8'hFF, 8'hFF);
		repeat (3) tick;
		acc(2'd1, 3'h3, `GPP_SEL_DATA, 8'hFF, 8'h00);
		chk(v, 8'h5A, "in");
		chk(oe[31:24], 8'h00, "oe");
		acc(2'd0, 3'h4, `GPP_SEL_PUR, 8'h00, 8'h3C);
		acc(2'd0, 3'h4, `GPP_SEL_PDR, 8'h00, 8'hC3);
		chk(pu, 64'h0000_003C_000F_8000, "pu");
		chk(pd, 64'h0000_00C3_0000_0000, "pd");
	endtask
	task t_trst;
		ext_en = 64'h0000_0000_0000_8000;
		ext_val = 64'h0;
		repeat (8) tick;
		chk(trst, 1'b0, "trst");
		acc(2'd0, `GPP_PORT_B, `GPP_SEL_AFSEL, 8'h00, 8'h00);
		chk(trst, 1'b1, "trst");
		ext_en = 64'h0;
	endtask
	task test_done;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) tick;
		rst_n = 1'b1;
		t_defaults;
		t_out;
		t_in;
		t_trst;
		rst_n = 1'b0;
		repeat (4) tick;
		rst_n = 1'b1;
		t_defaults;
		test_done;
	end
endmodule
bind gpp_top gpp_checker #(.N(N), .W(W)) u_gpp_checker (.clk_sys_in(clk_sys_in),
	.resetn_in(resetn_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
	.cfg_port_in(cfg_port_in), .cfg_sel_in(cfg_sel_in), .cfg_wdata_in(cfg_wdata_in),
	.data_addr_in(data_addr_in), .pad_in(pad_in), .pad_oe_out(pad_oe_out),
	.pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
	.cfg_rdata_out(cfg_rdata_out), .test_reset_n_out(test_reset_n_out));
